/* File: rcsu_pkg.sv */
// Package for the reset cause status unit: register map, field layout, types.
// Assumes an APB slave with 32-bit data, byte addresses on paddr.
package rcsu_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [31:0] RESET_CAUSE_STATUS_ADDR = 32'hFFFF0230;
    localparam logic [31:0] RESET_CAUSE_CLEAR_ADDR  = 32'hFFFF0234;
    localparam logic [31:0] INT_MASK_ADDR           = 32'hFFFF0238;
    localparam logic [31:0] INT_STATUS_ADDR         = 32'hFFFF023C;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int          STAT_W     = 8;
    localparam int          BIT_POR    = 0;
    localparam int          BIT_WDOG   = 1;
    localparam int          BIT_SOFT   = 2;
    localparam int          BIT_EXT    = 3;
    localparam int          NUM_CAUSE  = 4;
    localparam logic [7:0]  USED_MASK  = 8'h0F;
    localparam logic [7:0]  MASK_RESET = 8'h00;
    localparam logic [7:0]  STAT_RESET = 8'h01;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 4;
    localparam int RST_PULSE_NS      = 32;
    localparam int RST_PULSE_CYC     = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W         = 4;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } rcsu_apb_req_t;

    typedef struct packed {
        logic        pin_ext;
        logic        wdog_timeout;
        logic        por;
    } rcsu_events_t;

    typedef struct packed {
        logic        pins_default;
        logic        kernel_boot;
        logic        periph_reset;
        logic        wdog_reset;
        logic        ram_invalid;
    } rcsu_effects_t;

    typedef enum logic [1:0] {
        RCSU_IDLE  = 2'b01,
        RCSU_PULSE = 2'b10
    } rcsu_state_t;

endpackage : rcsu_pkg

/* File: rcsu_cause_bit.sv */
// One sticky reset-cause bit with set-over-clear priority.
// Assumes set and clear are single-cycle strobes in the pclk domain.
`timescale 1ns/1ns
module rcsu_cause_bit (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic set,
    input  wire logic clr,
    // State
    output logic      q
);
    logic next_q;

    always_comb begin
        next_q = q;
        if (clr) begin
            next_q = 1'b0;
        end
        if (set) begin
            next_q = 1'b1; // Event wins over clear
        end
    end

    // Cause survives every reset but the supply one, so presetn is only POR
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    setwins_a: assert property (@(posedge pclk) disable iff (!presetn)
        set |=> q) else $error("set did not win");

endmodule : rcsu_cause_bit

/* File: rcsu_top.sv */
// Reset cause status unit: records every reset source since the last clear, issues software
// resets and fans out per-source reset effects.
// Assumes presetn is the power-on reset; other events arrive as pulses.
//
// Summary of operation
// - Four reset sources are told apart and each cause seen since the last clear is kept in the status register.
// - The status register is eight bits wide and its value follows the reset kind.
// - Bit 3 sets on an external pin reset and holds until cleared.
// - Bit 1 sets on a watchdog timeout reset and holds until cleared.
// - Bit 0 sets on power-on reset and holds until cleared.
// - Writing 1 to bit 2 starts a software reset; the bit holds until cleared.
// - Bits 7 to 4 always read zero.
// - The write-only clear register mirrors the layout; a 1 clears that bit.
// - With bit 2 set, a clear write that keeps bit 2 starts another software reset.
// - Every reset puts pins in default state and runs the boot kernel.
// - Every reset resets peripherals and registers except the status register.
// - Only power-on resets the watchdog; RAM is flagged invalid only after power-on.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module rcsu_top #(
    parameter int PULSE_CYC = rcsu_pkg::RST_PULSE_CYC
) (
    // APB
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [31:0]          paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Reset events
    input  wire logic                 ext_pin_reset,
    input  wire logic                 wdog_timeout,
    // Reset effects
    output rcsu_pkg::rcsu_effects_t   effects,
    // Interrupt
    output logic                      irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rcsu_pkg::rcsu_state_t   st;
        logic [rcsu_pkg::RST_CNT_W-1:0] cnt;
        logic                    src_por;
        logic [7:0]              int_mask;
        logic [7:0]              int_stat;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        rcsu_pkg::rcsu_effects_t effects;
        logic                    irq;
        logic                    por_seen;
    } rcsu_regs_t;

    rcsu_regs_t r;
    rcsu_regs_t next_r;

    logic [rcsu_pkg::NUM_CAUSE-1:0] cause;
    logic [rcsu_pkg::NUM_CAUSE-1:0] cause_set;
    logic [rcsu_pkg::NUM_CAUSE-1:0] cause_clr;
    logic [7:0]                     status_rd;
    logic                           wr_acc;
    logic                           rd_acc;
    logic                           hit_stat;
    logic                           hit_clr;
    logic                           hit_mask;
    logic                           hit_istat;
    logic                           soft_req;
    logic                           any_evt;

    // ------------------------------------------------------------
    // Bus decode and cause bits
    // ------------------------------------------------------------
    assign wr_acc    = psel && penable && pwrite;
    assign rd_acc    = psel && penable && !pwrite;
    assign hit_stat  = paddr == rcsu_pkg::RESET_CAUSE_STATUS_ADDR;
    assign hit_clr   = paddr == rcsu_pkg::RESET_CAUSE_CLEAR_ADDR;
    assign hit_mask  = paddr == rcsu_pkg::INT_MASK_ADDR;
    assign hit_istat = paddr == rcsu_pkg::INT_STATUS_ADDR;

    // Software reset on a 1 to bit 2, or a clear write that keeps bit 2
    assign soft_req = wr_acc && ((hit_stat && pwdata[rcsu_pkg::BIT_SOFT])
        || (hit_clr && cause[rcsu_pkg::BIT_SOFT]
            && !pwdata[rcsu_pkg::BIT_SOFT]));

    always_comb begin
        cause_set = '0;
        cause_set[rcsu_pkg::BIT_POR]  = !r.por_seen;
        cause_set[rcsu_pkg::BIT_WDOG] = wdog_timeout;
        cause_set[rcsu_pkg::BIT_SOFT] = soft_req;
        cause_set[rcsu_pkg::BIT_EXT]  = ext_pin_reset;
        cause_clr = (wr_acc && hit_clr) ? pwdata[rcsu_pkg::NUM_CAUSE-1:0]
                                        : '0;
    end

    // Cause bits kept out of the block reset pulse
    genvar gi;
    generate
        for (gi = 0; gi < rcsu_pkg::NUM_CAUSE; gi++) begin : g_cause
            rcsu_cause_bit u_bit (
                .pclk    (pclk),
                .presetn (presetn),
                .set     (cause_set[gi]),
                .clr     (cause_clr[gi]),
                .q       (cause[gi])
            );
        end
    endgenerate

    // Upper bits tied low on read
    assign status_rd = {4'h0, cause} & rcsu_pkg::USED_MASK;
    assign any_evt   = |cause_set;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r          = r;
        next_r.por_seen = 1'b1;
        next_r.pready   = psel && !penable;
        next_r.pslverr  = 1'b0;
        next_r.int_stat = r.int_stat | {4'h0, cause_set};
        if (psel && !penable) begin
            next_r.prdata  = 32'h0000_0000;
            next_r.pslverr = !(hit_stat || hit_clr || hit_mask || hit_istat);
            if (!pwrite && hit_stat) begin
                next_r.prdata = {24'h00_0000, status_rd};
            end
            if (!pwrite && hit_mask) begin
                next_r.prdata = {24'h00_0000, r.int_mask};
            end
            // Events of the setup cycle are read now, as the access edge clears them
            if (!pwrite && hit_istat) begin
                next_r.prdata = {24'h00_0000, r.int_stat | {4'h0, cause_set}};
            end
        end
        if (rd_acc && hit_istat) begin
            next_r.int_stat = {4'h0, cause_set};
        end
        if (wr_acc && hit_mask) begin
            next_r.int_mask = pwdata[7:0] & rcsu_pkg::USED_MASK;
        end
        unique case (r.st)
            rcsu_pkg::RCSU_IDLE: begin
                if (any_evt) begin
                    next_r.st      = rcsu_pkg::RCSU_PULSE;
                    next_r.cnt     = rcsu_pkg::RST_CNT_W'(PULSE_CYC - 1);
                    next_r.src_por = cause_set[rcsu_pkg::BIT_POR];
                end
            end
            rcsu_pkg::RCSU_PULSE: begin
                if (r.cnt == '0) begin
                    next_r.st = rcsu_pkg::RCSU_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end
            default: next_r.st = rcsu_pkg::RCSU_IDLE;
        endcase
        next_r.effects.pins_default = next_r.st == rcsu_pkg::RCSU_PULSE;
        next_r.effects.kernel_boot  = next_r.st == rcsu_pkg::RCSU_PULSE;
        next_r.effects.periph_reset = next_r.st == rcsu_pkg::RCSU_PULSE;
        next_r.effects.wdog_reset   = next_r.st == rcsu_pkg::RCSU_PULSE
                                      && next_r.src_por;
        if (next_r.st == rcsu_pkg::RCSU_PULSE) begin
            next_r.effects.ram_invalid = next_r.src_por;
        end
        next_r.irq = |(next_r.int_stat & r.int_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.st       <= rcsu_pkg::RCSU_IDLE;
            r.int_mask <= rcsu_pkg::MASK_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign prdata  = r.prdata;
    assign pready  = r.pready;
    assign pslverr = r.pslverr;
    assign effects = r.effects;
    assign irq     = r.irq;

    // ------------------------------------------------------------
    // Cause checks
    // ------------------------------------------------------------
    ext_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
        ext_pin_reset |=> cause[rcsu_pkg::BIT_EXT])
        else $error("ext bit not set");
    wdog_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
        wdog_timeout |=> cause[rcsu_pkg::BIT_WDOG])
        else $error("wdog bit not set");
    por_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r.por_seen) |-> cause[rcsu_pkg::BIT_POR])
        else $error("por bit not set");
    por_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.por_seen |-> !cause_set[rcsu_pkg::BIT_POR])
        else $error("por cause raised twice");
    soft_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (soft_req && r.st == rcsu_pkg::RCSU_IDLE)
        |=> cause[rcsu_pkg::BIT_SOFT] && effects.periph_reset)
        else $error("soft reset missing");
    stat_wr_ign_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_stat && !(|cause_set)) |=> cause == $past(cause))
        else $error("status write changed a cause");
    upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_stat) |=> prdata[31:4] == '0)
        else $error("upper status bits set");
    clear_works_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_clr && pwdata[rcsu_pkg::BIT_EXT] && !ext_pin_reset)
        |=> !cause[rcsu_pkg::BIT_EXT]) else $error("clear failed");
    clr_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_clr) |=> (cause & ~$past(cause) & ~$past(cause_set)) == '0)
        else $error("clear write set a cause");
    resoft_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_clr && cause[rcsu_pkg::BIT_SOFT] && !pwdata[rcsu_pkg::BIT_SOFT]
        && r.st == rcsu_pkg::RCSU_IDLE) |=> effects.periph_reset)
        else $error("no repeat soft reset");
    stat_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
        (effects.periph_reset && !(|cause_clr)) |=> ($past(cause) & ~cause) == '0)
        else $error("status lost");

    // ------------------------------------------------------------
    // Pulse checks
    // ------------------------------------------------------------
    pins_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (any_evt && r.st == rcsu_pkg::RCSU_IDLE)
        |=> effects.pins_default && effects.kernel_boot) else $error("no pin default");
    pulse_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        (any_evt && r.st == rcsu_pkg::RCSU_IDLE)
        |=> r.cnt == rcsu_pkg::RST_CNT_W'(PULSE_CYC - 1))
        else $error("pulse count not loaded");
    // Length is held through the counter: a repetition would be too long to unroll
    pulse_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == rcsu_pkg::RCSU_PULSE && r.cnt != '0) |=> r.st == rcsu_pkg::RCSU_PULSE)
        else $error("pulse cut short");
    pulse_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == rcsu_pkg::RCSU_PULSE && r.cnt == '0) |=> r.st == rcsu_pkg::RCSU_IDLE)
        else $error("pulse overran");
    idle_stays_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == rcsu_pkg::RCSU_IDLE && !any_evt) |=> r.st == rcsu_pkg::RCSU_IDLE)
        else $error("pulse without event");
    fx_equal_a: assert property (@(posedge pclk) disable iff (!presetn)
        effects.periph_reset == (r.st == rcsu_pkg::RCSU_PULSE)
        && effects.pins_default == effects.periph_reset
        && effects.kernel_boot == effects.periph_reset) else $error("effects disagree");
    wdog_por_a: assert property (@(posedge pclk) disable iff (!presetn)
        effects.wdog_reset |-> r.src_por)
        else $error("wdog reset not por");
    por_fx_a: assert property (@(posedge pclk) disable iff (!presetn)
        (any_evt && r.st == rcsu_pkg::RCSU_IDLE && cause_set[rcsu_pkg::BIT_POR])
        |=> effects.wdog_reset && effects.ram_invalid) else $error("por effects missing");
    non_por_fx_a: assert property (@(posedge pclk) disable iff (!presetn)
        (any_evt && r.st == rcsu_pkg::RCSU_IDLE && !cause_set[rcsu_pkg::BIT_POR])
        |=> !effects.wdog_reset && !effects.ram_invalid)
        else $error("ram flagged without por");
    ram_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == rcsu_pkg::RCSU_IDLE && !any_evt) |=> $stable(effects.ram_invalid))
        else $error("ram flag moved");

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    ready_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("no ready after setup");
    ready_single_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && penable) |=> !pready)
        else $error("ready held too long");
    err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !(hit_stat || hit_clr || hit_mask || hit_istat))
        |=> pslverr && prdata == '0) else $error("unmapped access accepted");
    mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && (hit_stat || hit_clr || hit_mask || hit_istat))
        |=> !pslverr) else $error("mapped access refused");
    stat_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_stat)
        |=> prdata == {24'h00_0000, $past(status_rd)}) else $error("status read wrong");
    clr_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_clr) |=> prdata == '0)
        else $error("clear register readable");

    // ------------------------------------------------------------
    // Interrupt checks
    // ------------------------------------------------------------
    mask_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_mask)
        |=> prdata == {24'h00_0000, $past(r.int_mask)}) else $error("mask read wrong");
    mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_mask) |=> r.int_mask == ($past(pwdata[7:0]) & rcsu_pkg::USED_MASK))
        else $error("mask write lost");
    istat_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_istat)
        |=> prdata == {24'h00_0000, $past(r.int_stat) | {4'h0, $past(cause_set)}})
        else $error("int status read wrong");
    istat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && hit_istat) |=> r.int_stat == {4'h0, $past(cause_set)})
        else $error("int status not cleared");
    istat_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(rd_acc && hit_istat) |=> ($past(r.int_stat) & ~r.int_stat) == '0)
        else $error("int status bit dropped");
    irq_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.int_mask == '0) |=> !irq)
        else $error("irq while masked");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    soft_cov:   cover property (@(posedge pclk) soft_req);
    wdog_cov:   cover property (@(posedge pclk) wdog_timeout);
    irq_cov:    cover property (@(posedge pclk) $rose(irq));
    clash_cov:  cover property (@(posedge pclk) |(cause_clr & cause_set));
    resoft_cov: cover property (@(posedge pclk)
        wr_acc && hit_clr && cause[rcsu_pkg::BIT_SOFT] && !pwdata[rcsu_pkg::BIT_SOFT]);

endmodule : rcsu_top

/* File: tb_top.sv */
// Testbench for the reset cause status unit: APB register tests and reset events.
// Assumes rcsu_top answers APB with no wait states and takes one-cycle event pulses.
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    // Short pulse keeps the run brief; expectations follow this value
    localparam int          PULSE = 4;
    localparam logic [31:0] ST    = rcsu_pkg::RESET_CAUSE_STATUS_ADDR;
    localparam logic [31:0] CL    = rcsu_pkg::RESET_CAUSE_CLEAR_ADDR;
    localparam logic [31:0] MK    = rcsu_pkg::INT_MASK_ADDR;
    localparam logic [31:0] IS    = rcsu_pkg::INT_STATUS_ADDR;
    logic                    pclk;
    logic                    presetn;
    logic [31:0]             paddr;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [31:0]             pwdata;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    ext_pin_reset;
    logic                    wdog_timeout;
    rcsu_pkg::rcsu_effects_t effects;
    logic                    irq;
    logic [31:0]             rdat;
    logic                    rerr;
    int                      errors;
    int                      check_count;

    rcsu_top #(.PULSE_CYC(PULSE)) u_dut (
        .pclk          (pclk),
        .presetn       (presetn),
        .paddr         (paddr),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .ext_pin_reset (ext_pin_reset),
        .wdog_timeout  (wdog_timeout),
        .effects       (effects),
        .irq           (irq)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // Request held until pready is seen high; ev is driven in the access phase
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [1:0] ev);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        {ext_pin_reset, wdog_timeout} <= ev;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        {ext_pin_reset, wdog_timeout} <= 2'b00;
        psel    <= 1'b0;
        penable <= 1'b0;
        rdat = prdata;
        rerr = pslverr;
        if (n >= 20) begin
            errors++;
            $display("[ERR] %0t bus answer timed out", $time);
        end
        // Idle edge keeps a following call from driving psel twice in one step
        @(posedge pclk);
    endtask : apb

    task automatic pulse_ev(input logic [1:0] ev);
        {ext_pin_reset, wdog_timeout} <= ev;
        @(posedge pclk);
        {ext_pin_reset, wdog_timeout} <= 2'b00;
        @(posedge pclk);
    endtask : pulse_ev

    // Waits for the effects pulse, then measures its length
    task automatic fx_chk(input logic wd, input logic ri);
        int n;
        n = 0;
        while (effects.pins_default !== 1'b1 && n < 12) begin
            @(posedge pclk);
            n++;
        end
        chk(effects.wdog_reset, wd, "watchdog reset");
        chk({effects.kernel_boot, effects.periph_reset}, 2'b11, "boot");
        n = 0;
        while (effects.pins_default === 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        chk(n, PULSE, "pulse length");
        chk(effects.ram_invalid, ri, "ram flag");
    endtask : fx_chk

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        errors = 0;
        check_count = 0;
        {presetn, psel, penable, pwrite, ext_pin_reset, wdog_timeout} = 6'b000000;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        fx_chk(1'b1, 1'b1);
        apb(0, ST, 0, 0);
        chk(rdat, 32'h01, "power-on cause");
        apb(1, CL, 32'h01, 0);
        apb(0, ST, 0, 0);
        chk(rdat, 32'h00, "clear");
        $display("test power-on done");
        pulse_ev(2'b10);
        fx_chk(1'b0, 1'b0);
        apb(0, ST, 0, 0);
        chk(rdat, 32'h08, "pin cause");
        pulse_ev(2'b01);
        fx_chk(1'b0, 1'b0);
        apb(0, ST, 0, 0);
        chk(rdat, 32'h0A, "watchdog cause kept");
        $display("test events done");
        apb(1, ST, 32'hFF, 0);
        fx_chk(1'b0, 1'b0);
        apb(0, ST, 0, 0);
        chk(rdat, 32'h0E, "software cause");
        apb(1, CL, 32'h0A, 0);
        fx_chk(1'b0, 1'b0);
        apb(0, ST, 0, 0);
        chk(rdat, 32'h04, "partial clear");
        apb(1, CL, 32'h04, 0);
        apb(0, ST, 0, 0);
        chk(rdat, 32'h00, "soft clear");
        $display("test software reset done");
        pulse_ev(2'b01);
        fx_chk(1'b0, 1'b0);
        apb(1, CL, 32'h02, 2'b01);
        fx_chk(1'b0, 1'b0);
        apb(0, ST, 0, 0);
        chk(rdat, 32'h02, "set beats clear");
        apb(1, CL, 32'h02, 0);
        $display("test collision done");
        apb(1, 32'hFFFF0240, 32'hFF, 0);
        chk(rerr, 1'b1, "unmapped write");
        apb(0, 32'hFFFF0240, 0, 0);
        chk(rerr, 1'b1, "unmapped read error");
        chk(rdat, 32'h0, "unmapped read data");
        apb(0, CL, 0, 0);
        chk(rerr, 1'b0, "mapped access");
        chk(rdat, 32'h0, "clear reads zero");
        $display("test unmapped done");
        apb(1, MK, 32'h08, 0);
        apb(0, MK, 0, 0);
        chk(rdat, 32'h08, "mask");
        apb(0, IS, 0, 0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0, "irq idle");
        pulse_ev(2'b10);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1, "irq raised");
        apb(0, IS, 0, 0);
        chk(rdat & 32'h08, 32'h08, "int status");
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0, "irq cleared");
        pulse_ev(2'b01);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0, "irq masked");
        $display("test interrupt done");
        close_out();
    end

    // Whole sequence needs under two hundred cycles; this bound cuts a hang
    initial begin
        #40000;
        errors++;
        close_out();
    end
endmodule : tb_top
